// file: logic/lbrw_device.sv
// Memory-side command decode, bank state, read burst drive and write burst capture.
// Operation
// [RQ1] ACTIVATE decoded; bank and row opened
// [RQ2] Column access only after activation delay
// [RQ3] Open bank precharged before reactivation
// [RQ4] Activations spaced by row and bank gaps
// [RQ5] At most four activations per window
// [RQ6] Precharge-all uses the longer precharge time
// [RQ7] Column command: bit two picks read/write
// [RQ8] Interrupts only on four-bit boundaries
// [RQ9] Column from rising and falling halves
// [RQ10] Read data starts read_latency clocks later
// [RQ11] Strobe preamble, data edge-aligned with strobe
// [RQ12] Read-to-write turnaround spacing by controller
// [RQ13] Gapless reads at burst_length/2 spacing
// [RQ14] Reads interrupted only by read or stop
// [RQ15] Controller drives write data after write_latency
// [RQ16] Write beats sampled until burst complete
// [RQ17] Write recovery before precharge same bank
// [RQ18] Write-to-read turnaround spacing by controller
// [RQ19] Gapless writes at burst_length/2 spacing
// [RQ20] Writes interrupted only by write or stop
// [RQ21] Controller tracks rows, timers, activation history
`timescale 1ns/1ps
module lbrw_device (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic [lbrw_pkg::CA_W-1:0] cmd_addr_bus,
  input wire logic [lbrw_pkg::DQ_W-1:0] dq_in,
  input wire logic dqs_in,
  input wire logic [1:0] mode_burst_length,
  input wire logic [3:0] mode_read_latency,
  input wire logic [3:0] mode_write_latency,
  input wire logic store_ready,
  output logic [lbrw_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic dqs_out,
  output logic dqs_oe,
  output logic store_valid,
  output logic [lbrw_pkg::ENTRY_W-1:0] store_data,
  output logic [lbrw_pkg::BANKS-1:0] bank_open,
  output logic [lbrw_pkg::ROW_W-1:0] act_row,
  output logic cmd_err,
  output logic overflow
);
  logic [lbrw_pkg::PIN_W-1:0] sync1, sync2;
  logic ck_d, dqs_d;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      ck_d <= 1'b0;
      dqs_d <= 1'b0;
    end else begin
      sync1 <= {mode_write_latency, mode_read_latency, mode_burst_length, dqs_in, dq_in,
                cmd_addr_bus, cs_n, ck};
      sync2 <= sync1;
      ck_d <= sync2[lbrw_pkg::P_CK];
      dqs_d <= sync2[lbrw_pkg::P_DQS];
    end
  end

  logic ck_rise, ck_fall, dqs_rise, dqs_fall;
  logic [lbrw_pkg::CA_W-1:0] ca;
  logic [lbrw_pkg::BEAT_W-1:0] cfg_len;
  logic [lbrw_pkg::CNT_W-1:0] ck_count, now_cnt;
  assign ck_rise = sync2[lbrw_pkg::P_CK] && !ck_d;
  assign ck_fall = !sync2[lbrw_pkg::P_CK] && ck_d;
  assign dqs_rise = sync2[lbrw_pkg::P_DQS] && !dqs_d;
  assign dqs_fall = !sync2[lbrw_pkg::P_DQS] && dqs_d;
  assign ca = sync2[lbrw_pkg::P_CA +: lbrw_pkg::CA_W];
  assign cfg_len = lbrw_pkg::lbrw_beats(sync2[lbrw_pkg::P_BL +: 2]);
  assign now_cnt = ck_rise ? lbrw_pkg::CNT_W'(ck_count + 1) : ck_count;

  // A command is latched on the clock's rising edge and executed on the following falling
  // edge, where its second address half is available.
  logic cmd_pend;
  logic [lbrw_pkg::CA_W-1:0] cmd_ca;
  logic [lbrw_pkg::CNT_W-1:0] cmd_time;
  logic exec, exec_act, exec_cas, exec_rd, exec_wr, exec_pre;
  logic [lbrw_pkg::BA_W-1:0] exec_ba;
  logic [lbrw_pkg::COL_W-1:0] exec_col;
  assign exec = cmd_pend && ck_fall;
  assign exec_act = exec && cmd_ca[1:0] == lbrw_pkg::CMD_ACT; // RQ1
  assign exec_cas = exec && cmd_ca[1:0] == lbrw_pkg::CMD_CAS; // RQ7
  assign exec_rd = exec_cas && cmd_ca[lbrw_pkg::CA_RD]; // RQ7
  assign exec_wr = exec_cas && !cmd_ca[lbrw_pkg::CA_RD]; // RQ7
  assign exec_pre = exec && cmd_ca[3:0] == lbrw_pkg::CMD_PRE;
  assign exec_ba = cmd_ca[lbrw_pkg::CA_BA_LSB +: lbrw_pkg::BA_W]; // RQ1
  assign exec_col = {ca[9:1], cmd_ca[lbrw_pkg::CA_COLR_LSB +: 2]}; // RQ9

  logic [lbrw_pkg::DQ_W-1:0] mem [lbrw_pkg::MEM_DEPTH];
  logic [lbrw_pkg::DQ_W-1:0] next_mem [lbrw_pkg::MEM_DEPTH];
  logic next_cmd_pend, next_cmd_err;
  logic [lbrw_pkg::CA_W-1:0] next_cmd_ca;
  logic [lbrw_pkg::CNT_W-1:0] next_cmd_time;
  logic [lbrw_pkg::BANKS-1:0] next_bank_open;
  logic [lbrw_pkg::ROW_W-1:0] next_act_row;
  lbrw_stream_if buf_if ();
  lbrw_pair_buf u_buf (.core_clk(core_clk), .resetn(resetn), .port(buf_if.fifo));
  assign buf_if.out_ready = store_ready;
  assign store_valid = buf_if.out_valid;
  assign store_data = buf_if.out_data;

  always_comb begin
    next_cmd_pend = cmd_pend;
    next_cmd_ca = cmd_ca;
    next_cmd_time = cmd_time;
    next_bank_open = bank_open;
    next_act_row = act_row;
    next_cmd_err = 1'b0;
    next_mem = mem;
    if (ck_rise) begin
      next_cmd_pend = !sync2[lbrw_pkg::P_CS];
      next_cmd_ca = ca;
      next_cmd_time = now_cnt;
    end else if (ck_fall) begin
      next_cmd_pend = 1'b0;
    end
    if (exec_act) begin
      next_cmd_err = bank_open[exec_ba];
      next_bank_open[exec_ba] = 1'b1; // RQ1
      next_act_row = {ca, cmd_ca[lbrw_pkg::CA_ROWR_LSB +: 5]}; // RQ1
    end
    if (exec_cas) begin
      next_cmd_err = !bank_open[exec_ba];
    end
    if (exec_pre) begin
      if (cmd_ca[lbrw_pkg::CA_AB]) begin
        next_bank_open = '0;
      end else begin
        next_bank_open[exec_ba] = 1'b0;
      end
    end
    // Only drained beats reach the array; while the store side stalls, beats arriving with both entries full are dropped and flagged on overflow.
    if (buf_if.out_valid && store_ready) begin
      next_mem[buf_if.out_data[lbrw_pkg::DQ_W +: lbrw_pkg::MEM_AW]] =
        buf_if.out_data[lbrw_pkg::DQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cmd_pend <= 1'b0;
      cmd_ca <= '0;
      cmd_time <= lbrw_pkg::CNT_RESET;
      ck_count <= lbrw_pkg::CNT_RESET;
      bank_open <= '0;
      act_row <= lbrw_pkg::ROW_RESET;
      cmd_err <= 1'b0;
      for (int i = 0; i < lbrw_pkg::MEM_DEPTH; i++) begin
        mem[i] <= lbrw_pkg::DATA_RESET;
      end
    end else begin
      cmd_pend <= next_cmd_pend;
      cmd_ca <= next_cmd_ca;
      cmd_time <= next_cmd_time;
      ck_count <= now_cnt;
      bank_open <= next_bank_open;
      act_row <= next_act_row;
      cmd_err <= next_cmd_err;
      mem <= next_mem;
    end
  end

  // Read burst engine with one queued burst for seamless or interrupting reads.
  lbrw_pkg::lbrw_rd_state_t rd_state, next_rd_state;
  logic [lbrw_pkg::CNT_W-1:0] rd_start, rd_nstart, next_rd_start, next_rd_nstart, rd_lat;
  logic [lbrw_pkg::COL_W-1:0] rd_col, rd_ncol, next_rd_col, next_rd_ncol;
  logic [lbrw_pkg::BEAT_W-1:0] rd_len, rd_nlen, rd_beat, next_rd_len, next_rd_nlen, next_rd_beat;
  logic rd_nv, next_rd_nv, next_dq_oe, next_dqs_out, next_dqs_oe;
  logic [lbrw_pkg::DQ_W-1:0] next_dq_out;
  assign rd_lat = lbrw_pkg::CNT_W'(sync2[lbrw_pkg::P_RL +: 4]);

  always_comb begin
    next_rd_state = rd_state;
    next_rd_start = rd_start;
    next_rd_col = rd_col;
    next_rd_len = rd_len;
    next_rd_beat = rd_beat;
    next_rd_nv = rd_nv;
    next_rd_nstart = rd_nstart;
    next_rd_ncol = rd_ncol;
    next_rd_nlen = rd_nlen;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    next_dqs_out = dqs_out;
    next_dqs_oe = dqs_oe;
    unique case (rd_state)
      lbrw_pkg::LBRW_RD_IDLE: begin
        next_dqs_oe = 1'b0;
      end
      lbrw_pkg::LBRW_RD_WAIT: begin
        if (ck_rise && now_cnt == lbrw_pkg::CNT_W'(rd_start - 1)) begin
          next_rd_state = lbrw_pkg::LBRW_RD_PRE; // RQ11
          next_dqs_oe = 1'b1;
          next_dq_oe = 1'b1;
          next_dqs_out = 1'b0;
        end
      end
      lbrw_pkg::LBRW_RD_PRE: begin
        if (ck_rise) begin
          next_rd_state = lbrw_pkg::LBRW_RD_BURST; // RQ10
          next_dqs_out = 1'b1; // RQ11
          next_dq_out = mem[rd_col[lbrw_pkg::MEM_AW-1:0]];
          next_rd_beat = 5'h01;
        end
      end
      lbrw_pkg::LBRW_RD_BURST: begin
        if (ck_rise && rd_nv && now_cnt == rd_nstart) begin
          next_rd_col = rd_ncol; // RQ13
          next_rd_len = rd_nlen;
          next_rd_nv = 1'b0;
          next_dqs_out = 1'b1;
          next_dq_out = mem[rd_ncol[lbrw_pkg::MEM_AW-1:0]];
          next_rd_beat = 5'h01;
        end else if (ck_rise || ck_fall) begin
          if (rd_beat == rd_len) begin
            next_rd_state = lbrw_pkg::LBRW_RD_IDLE;
            next_dqs_oe = 1'b0;
            next_dq_oe = 1'b0;
            next_dqs_out = 1'b0;
            if (rd_nv) begin
              next_rd_state = lbrw_pkg::LBRW_RD_WAIT;
              next_rd_start = rd_nstart;
              next_rd_col = rd_ncol;
              next_rd_len = rd_nlen;
              next_rd_nv = 1'b0;
              if (ck_rise && now_cnt == lbrw_pkg::CNT_W'(rd_nstart - 1)) begin
                next_rd_state = lbrw_pkg::LBRW_RD_PRE;
                next_dqs_oe = 1'b1;
                next_dq_oe = 1'b1;
              end
            end
          end else begin
            next_dqs_out = ck_rise; // RQ11
            next_dq_out = mem[lbrw_pkg::MEM_AW'(rd_col + lbrw_pkg::COL_W'(rd_beat))];
            next_rd_beat = rd_beat + 5'h01;
          end
        end
      end
      default: begin
        next_rd_state = lbrw_pkg::LBRW_RD_IDLE;
      end
    endcase
    if (exec_rd) begin
      if (rd_state == lbrw_pkg::LBRW_RD_IDLE) begin
        next_rd_state = lbrw_pkg::LBRW_RD_WAIT;
        next_rd_start = lbrw_pkg::CNT_W'(cmd_time + rd_lat); // RQ10
        next_rd_col = exec_col;
        next_rd_len = cfg_len;
      end else begin
        next_rd_nv = 1'b1;
        next_rd_nstart = lbrw_pkg::CNT_W'(cmd_time + rd_lat);
        next_rd_ncol = exec_col;
        next_rd_nlen = cfg_len;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_state <= lbrw_pkg::LBRW_RD_IDLE;
      rd_start <= lbrw_pkg::CNT_RESET;
      rd_col <= lbrw_pkg::COL_RESET;
      rd_len <= lbrw_pkg::BEAT_RESET;
      rd_beat <= lbrw_pkg::BEAT_RESET;
      rd_nv <= 1'b0;
      rd_nstart <= lbrw_pkg::CNT_RESET;
      rd_ncol <= lbrw_pkg::COL_RESET;
      rd_nlen <= lbrw_pkg::BEAT_RESET;
      dq_out <= lbrw_pkg::DATA_RESET;
      dq_oe <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
    end else begin
      rd_state <= next_rd_state;
      rd_start <= next_rd_start;
      rd_col <= next_rd_col;
      rd_len <= next_rd_len;
      rd_beat <= next_rd_beat;
      rd_nv <= next_rd_nv;
      rd_nstart <= next_rd_nstart;
      rd_ncol <= next_rd_ncol;
      rd_nlen <= next_rd_nlen;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      dqs_out <= next_dqs_out;
      dqs_oe <= next_dqs_oe;
    end
  end

  // Write capture: from the first rising strobe edge of an open burst on, each strobe edge yields one beat toward the buffer.
  logic wr_act, wr_seen, wr_nv, push_valid;
  logic next_wr_act, next_wr_seen, next_wr_nv, next_push_valid, next_overflow;
  logic [lbrw_pkg::BA_W-1:0] wr_bank, wr_nbank, next_wr_bank, next_wr_nbank;
  logic [lbrw_pkg::COL_W-1:0] wr_col, wr_ncol, next_wr_col, next_wr_ncol;
  logic [lbrw_pkg::BEAT_W-1:0] wr_len, wr_nlen, wr_beat, next_wr_len, next_wr_nlen, next_wr_beat;
  logic [lbrw_pkg::CNT_W-1:0] wr_nstart, next_wr_nstart;
  logic [lbrw_pkg::ENTRY_W-1:0] push_data, next_push_data;
  logic [lbrw_pkg::DQ_W-1:0] wdat;
  assign wdat = sync2[lbrw_pkg::P_DQ +: lbrw_pkg::DQ_W];
  assign buf_if.in_valid = push_valid;
  assign buf_if.in_data = push_data;

  always_comb begin
    next_wr_act = wr_act;
    next_wr_seen = wr_seen;
    next_wr_nv = wr_nv;
    next_wr_bank = wr_bank;
    next_wr_nbank = wr_nbank;
    next_wr_col = wr_col;
    next_wr_ncol = wr_ncol;
    next_wr_len = wr_len;
    next_wr_nlen = wr_nlen;
    next_wr_beat = wr_beat;
    next_wr_nstart = wr_nstart;
    next_push_valid = 1'b0;
    next_push_data = push_data;
    next_overflow = push_valid && !buf_if.in_ready;
    if (wr_act && (dqs_rise || (dqs_fall && wr_seen))) begin
      next_push_valid = 1'b1;
      next_wr_seen = 1'b1;
      if (dqs_rise && wr_nv && now_cnt == wr_nstart) begin
        next_wr_col = wr_ncol; // RQ19
        next_wr_bank = wr_nbank;
        next_wr_len = wr_nlen;
        next_wr_nv = 1'b0;
        next_wr_beat = 5'h01;
        next_push_data = {wr_nbank, wr_ncol, wdat};
      end else begin
        next_push_data = {wr_bank, lbrw_pkg::COL_W'(wr_col + lbrw_pkg::COL_W'(wr_beat)), wdat};
        next_wr_beat = wr_beat + 5'h01; // RQ16
        if (wr_beat + 5'h01 == wr_len) begin
          next_wr_act = wr_nv; // RQ16
          next_wr_seen = 1'b0;
          next_wr_beat = lbrw_pkg::BEAT_RESET;
          next_wr_col = wr_ncol;
          next_wr_bank = wr_nbank;
          next_wr_len = wr_nlen;
          next_wr_nv = 1'b0;
        end
      end
    end
    if (exec_wr) begin
      if (!next_wr_act) begin
        next_wr_act = 1'b1;
        next_wr_seen = 1'b0;
        next_wr_beat = lbrw_pkg::BEAT_RESET;
        next_wr_col = exec_col; // RQ9
        next_wr_bank = exec_ba;
        next_wr_len = cfg_len;
      end else begin
        next_wr_nv = 1'b1;
        next_wr_ncol = exec_col;
        next_wr_nbank = exec_ba;
        next_wr_nlen = cfg_len;
        next_wr_nstart = lbrw_pkg::CNT_W'(cmd_time + lbrw_pkg::CNT_W'(sync2[lbrw_pkg::P_WL +: 4]));
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_act <= 1'b0;
      wr_seen <= 1'b0;
      wr_nv <= 1'b0;
      wr_bank <= '0;
      wr_nbank <= '0;
      wr_col <= lbrw_pkg::COL_RESET;
      wr_ncol <= lbrw_pkg::COL_RESET;
      wr_len <= lbrw_pkg::BEAT_RESET;
      wr_nlen <= lbrw_pkg::BEAT_RESET;
      wr_beat <= lbrw_pkg::BEAT_RESET;
      wr_nstart <= lbrw_pkg::CNT_RESET;
      push_valid <= 1'b0;
      push_data <= '0;
      overflow <= 1'b0;
    end else begin
      wr_act <= next_wr_act;
      wr_seen <= next_wr_seen;
      wr_nv <= next_wr_nv;
      wr_bank <= next_wr_bank;
      wr_nbank <= next_wr_nbank;
      wr_col <= next_wr_col;
      wr_ncol <= next_wr_ncol;
      wr_len <= next_wr_len;
      wr_nlen <= next_wr_nlen;
      wr_beat <= next_wr_beat;
      wr_nstart <= next_wr_nstart;
      push_valid <= next_push_valid;
      push_data <= next_push_data;
      overflow <= next_overflow;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_ACT_OPENS_BANK: assert property (exec_act |=> bank_open[$past(exec_ba)]) // RQ1
    else $error("activate did not open its bank");
  AST_READ_DECODE: assert property (exec_rd |=> rd_state != lbrw_pkg::LBRW_RD_IDLE) // RQ7
    else $error("read command left the read engine idle");
  AST_COL_CAPTURE: assert property (exec_rd |=>
    (rd_col == $past(exec_col) || rd_ncol == $past(exec_col))) // RQ9
    else $error("read column not taken from both command halves");
  AST_DATA_AT_LATENCY: assert property ((rd_state == lbrw_pkg::LBRW_RD_PRE && ck_rise)
    |-> now_cnt == rd_start ##1 (rd_state == lbrw_pkg::LBRW_RD_BURST && dqs_out)) // RQ10
    else $error("first read beat not at read latency");
  AST_PREAMBLE_LOW: assert property (rd_state == lbrw_pkg::LBRW_RD_WAIT ##1
    rd_state == lbrw_pkg::LBRW_RD_PRE |-> dqs_oe && !dqs_out) // RQ11
    else $error("read preamble not driven low");
  AST_NO_BURST_WITHOUT_PRE: assert property (rd_state == lbrw_pkg::LBRW_RD_WAIT
    |=> rd_state != lbrw_pkg::LBRW_RD_BURST) // RQ11
    else $error("read burst started without preamble");
  AST_RISE_STROBE_HIGH: assert property ((rd_state == lbrw_pkg::LBRW_RD_BURST && ck_rise)
    |=> (rd_state != lbrw_pkg::LBRW_RD_BURST || (dqs_out && dq_oe))) // RQ11
    else $error("strobe not high with rising-edge beat");
  AST_FALL_STROBE_LOW: assert property ((rd_state == lbrw_pkg::LBRW_RD_BURST && ck_fall)
    |=> !dqs_out) // RQ11
    else $error("strobe not low with falling-edge beat");
  AST_SEAMLESS_READ: assert property ((rd_state == lbrw_pkg::LBRW_RD_BURST && ck_rise &&
    rd_nv && now_cnt == rd_nstart) |=> (rd_state == lbrw_pkg::LBRW_RD_BURST && rd_beat == 5'h01
    && dqs_oe)) // RQ13
    else $error("queued read did not follow without a gap");
  AST_WRITE_BEAT_BOUND: assert property (wr_act |-> wr_beat < wr_len) // RQ16
    else $error("write beat count passed burst length");
  AST_PUSH_ON_STROBE: assert property (push_valid |-> $past(dqs_rise || dqs_fall)) // RQ16
    else $error("write beat captured without strobe edge");
  AST_SEAMLESS_WRITE: assert property ((dqs_rise && wr_act && wr_nv && now_cnt == wr_nstart)
    |=> (wr_beat == 5'h01 && wr_col == $past(wr_ncol) && push_valid)) // RQ19
    else $error("queued write did not follow without a gap");

  COV_READ_BURST: cover property (rd_state == lbrw_pkg::LBRW_RD_BURST && rd_beat == rd_len);
  COV_SEAMLESS_READ: cover property (rd_state == lbrw_pkg::LBRW_RD_BURST && rd_nv && ck_rise
    && now_cnt == rd_nstart);
  COV_WRITE_DONE: cover property (wr_act ##1 !wr_act);
  COV_BUFFER_FULL: cover property (!buf_if.in_ready);
endmodule

// file: logic/lbrw_pkg.sv
// Shared constants, pin layout, command codes and state type for the bank access block.
package lbrw_pkg;
  localparam int CA_W = 10;
  localparam int DQ_W = 8;
  localparam int BANKS = 8;
  localparam int BA_W = 3;
  localparam int ROW_W = 15;
  localparam int COL_W = 11;
  localparam int CNT_W = 8;
  localparam int BEAT_W = 5;
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  localparam int BUF_DEPTH = 2;
  localparam int ENTRY_W = BA_W + COL_W + DQ_W;

  // Bit positions inside the synchronised pin vector.
  localparam int P_CK = 0;
  localparam int P_CS = 1;
  localparam int P_CA = 2;
  localparam int P_DQ = 12;
  localparam int P_DQS = 20;
  localparam int P_BL = 21;
  localparam int P_RL = 23;
  localparam int P_WL = 27;
  localparam int PIN_W = 31;

  // Command bus field positions on the rising half of a command.
  localparam int CA_BA_LSB = 7;
  localparam int CA_COLR_LSB = 5;
  localparam int CA_ROWR_LSB = 2;
  localparam int CA_AB = 4;
  localparam int CA_RD = 2;
  localparam logic [1:0] CMD_ACT = 2'h2;
  localparam logic [1:0] CMD_CAS = 2'h1;
  localparam logic [3:0] CMD_PRE = 4'hB;

  // Burst length codes on the mode pins.
  localparam logic [1:0] BL_CODE_4 = 2'h0;
  localparam logic [1:0] BL_CODE_8 = 2'h1;
  localparam logic [BEAT_W-1:0] BEATS_4 = 5'h04;
  localparam logic [BEAT_W-1:0] BEATS_8 = 5'h08;
  localparam logic [BEAT_W-1:0] BEATS_16 = 5'h10;

  // Values after reset.
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [DQ_W-1:0] DATA_RESET = 8'h00;
  localparam logic [BEAT_W-1:0] BEAT_RESET = 5'h00;
  localparam logic [COL_W-1:0] COL_RESET = 11'h000;
  localparam logic [ROW_W-1:0] ROW_RESET = 15'h0000;

  typedef enum logic [3:0] {
    LBRW_RD_IDLE = 4'b0001,
    LBRW_RD_WAIT = 4'b0010,
    LBRW_RD_PRE = 4'b0100,
    LBRW_RD_BURST = 4'b1000
  } lbrw_rd_state_t;

  function automatic logic [BEAT_W-1:0] lbrw_beats(input logic [1:0] code);
    logic [BEAT_W-1:0] n;
    n = BEATS_16;
    if (code == BL_CODE_4) begin
      n = BEATS_4;
    end else if (code == BL_CODE_8) begin
      n = BEATS_8;
    end
    return n;
  endfunction
endpackage

// file: logic/lbrw_stream_if.sv
// Valid/ready carrier between the write capture logic and the two-entry buffer.
`timescale 1ns/1ps
interface lbrw_stream_if;
  logic in_valid;
  logic in_ready;
  logic [lbrw_pkg::ENTRY_W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [lbrw_pkg::ENTRY_W-1:0] out_data;
  modport core (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data);
endinterface

// file: logic/lbrw_pair_buf.sv
// Two-entry buffer holding captured write beats until the store side takes them.
`timescale 1ns/1ps
module lbrw_pair_buf (
  input wire logic core_clk,
  input wire logic resetn,
  lbrw_stream_if.fifo port
);
  logic [lbrw_pkg::ENTRY_W-1:0] slot [lbrw_pkg::BUF_DEPTH];
  logic [lbrw_pkg::ENTRY_W-1:0] next_slot [lbrw_pkg::BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] fill;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic [1:0] next_fill;
  logic push;
  logic pop;

  assign port.in_ready = (fill != 2'(lbrw_pkg::BUF_DEPTH));
  assign port.out_valid = (fill != 2'h0);
  assign port.out_data = slot[rd_ptr];
  assign push = port.in_valid && port.in_ready;
  assign pop = port.out_valid && port.out_ready;

  always_comb begin
    next_slot = slot;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill = fill;
    if (push) begin
      next_slot[wr_ptr] = port.in_data;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_fill = fill + 2'h1;
    end else if (pop && !push) begin
      next_fill = fill - 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int i = 0; i < lbrw_pkg::BUF_DEPTH; i++) begin
        slot[i] <= '0;
      end
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill <= 2'h0;
    end else begin
      slot <= next_slot;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end
endmodule

// file: bench/lbrw_ctl_model.sv
// Controller-side model driving link clock, command bus and write data.
`timescale 1ns/1ps
module lbrw_ctl_model (
  output logic ck,
  output logic cs_n,
  output logic [9:0] ca,
  output logic [7:0] dq,
  output logic dqs
);
  initial begin
    ck = 1'h0;
    cs_n = 1'h1;
    ca = 10'h000;
    dq = 8'h00;
    dqs = 1'h0;
  end
  // One link cycle; ck stands low between calls and dq toggles when undriven.
  task automatic cyc(input logic sel, input logic [9:0] r, input logic [9:0] f,
                     input logic wr, input logic [7:0] a, input logic [7:0] b);
    cs_n = ~sel;
    ca = r;
    ck = 1'h1;
    dq = wr ? a : ~dq;
    #200 dqs = wr;
    #100 ca = f;
    #100 ck = 1'h0;
    dq = wr ? b : ~dq;
    #200 dqs = 1'h0;
    #200;
  endtask
endmodule

// file: bench/lbrw_device_test.sv
// Self-checking bench for the bank access block.
`timescale 1ns/1ps
module lbrw_device_test;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic store_ready = 1'h0;
  logic ck, cs_n, mdqs, dq_oe, dqs_out, dqs_oe, store_valid, cmd_err, overflow;
  logic [9:0] ca;
  logic [7:0] mdq, dq_out;
  logic [21:0] store_data;
  logic [7:0] bank_open;
  logic [14:0] act_row;
  logic [21:0] got[$];
  logic [7:0] beats[$];
  int n_errors = 0, compares = 0, n_err = 0, n_ovf = 0, n_pre = 0;
  logic pdqs = 1'h0, poe = 1'h0;
  logic [1:0] bl_code = 2'h0;
  time t_first = 0, tc;
  always #50 core_clk = ~core_clk;
  lbrw_ctl_model u_lbrw_ctl_model (.ck(ck), .cs_n(cs_n), .ca(ca), .dq(mdq), .dqs(mdqs));
  lbrw_device u_lbrw_device (.core_clk(core_clk), .resetn(resetn), .ck(ck), .cs_n(cs_n),
    .cmd_addr_bus(ca), .dq_in(dq_oe ? dq_out : mdq), .dqs_in(dqs_oe ? dqs_out : mdqs),
    .mode_burst_length(bl_code), .mode_read_latency(4'h3), .mode_write_latency(4'h1),
    .store_ready(store_ready), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe), .store_valid(store_valid), .store_data(store_data),
    .bank_open(bank_open), .act_row(act_row), .cmd_err(cmd_err), .overflow(overflow));
  always @(posedge core_clk) begin
    if (store_valid && store_ready) got.push_back(store_data);
    if (dq_oe && dqs_out !== pdqs) beats.push_back(dq_out);
    if (dqs_out && !pdqs && t_first == 0) t_first = $time;
    if (dqs_oe && !poe) begin
      n_pre++;
      check("preamble strobe", 32'h0, {31'h0, dqs_out});
    end
    n_err += cmd_err;
    n_ovf += overflow;
    pdqs = dqs_out;
    poe = dqs_oe;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic cy(input logic s, input logic [9:0] r, input logic [9:0] f,
                    input logic w, input logic [7:0] a, input logic [7:0] b);
    u_lbrw_ctl_model.cyc(s, r, f, w, a, b);
  endtask
  task automatic idle(input int n);
    repeat (n) cy(1'h0, 10'h000, 10'h000, 1'h0, 8'h00, 8'h00);
  endtask
  function automatic logic [9:0] cas(input logic [2:0] bk, input logic rd, input logic [1:0] c);
    return {bk, c, 2'h0, rd, 2'h1};
  endfunction
  task automatic t_act;
    cy(1'h1, {3'h3, 5'h15, 2'h2}, 10'h2A5, 1'h0, 8'h00, 8'h00);
    idle(2);
    check("bank_open", 32'h08, {24'h0, bank_open});
    check("act_row", 32'h54B5, {17'h0, act_row});
    cy(1'h1, {3'h3, 5'h00, 2'h2}, 10'h000, 1'h0, 8'h00, 8'h00);
    cy(1'h1, cas(3'h5, 1'h1, 2'h0), 10'h000, 1'h0, 8'h00, 8'h00);
    idle(7);
    check("error pulses", 32'h2, n_err);
    $display("test activate done");
  endtask
  task automatic t_wr;
    store_ready = 1'h1;
    got.delete();
    cy(1'h1, cas(3'h3, 1'h0, 2'h0), 10'h000, 1'h0, 8'h00, 8'h00);
    cy(1'h0, 10'h000, 10'h000, 1'h1, 8'hA0, 8'hA1);
    cy(1'h1, cas(3'h3, 1'h0, 2'h0), 10'h002, 1'h1, 8'hA2, 8'hA3);
    cy(1'h0, 10'h000, 10'h000, 1'h1, 8'hA4, 8'hA5);
    cy(1'h0, 10'h000, 10'h000, 1'h1, 8'hA6, 8'hA7);
    idle(3);
    check("entry count", 32'h8, got.size());
    for (int i = 0; i < 8; i++) begin
      check("store entry", {13'h3, 11'(i), 8'hA0 + 8'(i)}, {10'h0, got[i]});
    end
    $display("test gapless writes done");
  endtask
  task automatic t_rd;
    beats.delete();
    n_pre = 0;
    t_first = 0;
    tc = $time;
    cy(1'h1, cas(3'h3, 1'h1, 2'h0), 10'h000, 1'h0, 8'h00, 8'h00);
    idle(1);
    cy(1'h1, cas(3'h3, 1'h1, 2'h0), 10'h002, 1'h0, 8'h00, 8'h00);
    idle(7);
    check("read latency", 32'h1, {31'h0, t_first - tc >= 2400 && t_first - tc <= 3000});
    check("preambles", 32'h1, n_pre);
    check("beat count", 32'h8, beats.size());
    for (int i = 0; i < 8; i++) begin
      check("read beat", {24'h0, 8'hA0 + 8'(i)}, {24'h0, beats[i]});
    end
    $display("test gapless reads done");
  endtask
  task automatic t_stall;
    store_ready = 1'h0;
    got.delete();
    n_ovf = 0;
    cy(1'h1, cas(3'h3, 1'h0, 2'h0), 10'h004, 1'h0, 8'h00, 8'h00);
    cy(1'h0, 10'h000, 10'h000, 1'h1, 8'hB0, 8'hB1);
    cy(1'h0, 10'h000, 10'h000, 1'h1, 8'hB2, 8'hB3);
    idle(3);
    check("lost beats", 32'h2, n_ovf);
    check("store_valid held", 32'h1, {31'h0, store_valid});
    store_ready = 1'h1;
    idle(1);
    check("drained count", 32'h2, got.size());
    check("entry 0", {13'h3, 11'h008, 8'hB0}, {10'h0, got[0]});
    check("entry 1", {13'h3, 11'h009, 8'hB1}, {10'h0, got[1]});
    $display("test stalled buffer done");
  endtask
  task automatic t_rd8;
    bl_code = 2'h1;
    beats.delete();
    cy(1'h1, cas(3'h3, 1'h1, 2'h0), 10'h000, 1'h0, 8'h00, 8'h00);
    idle(7);
    bl_code = 2'h0;
    check("beat count", 32'h8, beats.size());
    for (int i = 0; i < 8; i++) begin
      check("read beat", {24'h0, 8'hA0 + 8'(i)}, {24'h0, beats[i]});
    end
    $display("test eight-beat read done");
  endtask
  task automatic t_pre;
    cy(1'h1, {3'h6, 5'h00, 2'h2}, 10'h000, 1'h0, 8'h00, 8'h00);
    cy(1'h1, 10'h18B, 10'h000, 1'h0, 8'h00, 8'h00);
    check("bank_open", 32'h40, {24'h0, bank_open});
    cy(1'h1, 10'h01B, 10'h000, 1'h0, 8'h00, 8'h00);
    check("bank_open", 32'h0, {24'h0, bank_open});
    cy(1'h1, {3'h3, 5'h00, 2'h2}, 10'h000, 1'h0, 8'h00, 8'h00);
    check("bank_open", 32'h08, {24'h0, bank_open});
    check("error pulses", 32'h2, n_err);
    $display("test precharge done");
  endtask
  task automatic conclude;
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    #1 resetn = 1'h1;
    repeat (3) @(posedge core_clk);
    #1;
    t_act;
    t_wr;
    t_rd;
    t_rd8;
    t_stall;
    t_pre;
    conclude;
  end
  initial begin
    #300000;
    n_errors++;
    conclude;
  end
endmodule
